// [rtl/ppg_ctrl.sv]
// peripheral power gating controller: disable registers, write lock,
// per-peripheral clock gates and regulator sleep sequencing
// assumes one 10 mhz system clock, sync reset, axi4-lite master outside
`timescale 1ns/1ps

// Function
// - set disable bit stops peripheral clock
// - disable bits reset cleared, clear re-enables
// - disabled peripheral registers ignore writes; here periph_off only gates the clock
// - locked disable writes complete okay, unchanged
// - bit 11 lock blocks disable writes
// - lock changes need system unlock first
// - disable 1: converter, vref, volt detect
// - disable 2: comparators, logic cells
// - disable 3: capture compare units
// - disable 5: uarts and spis
// - disable 4 timer, 6 rtc, refclk
// - disable 7: checksum engine
// - standby bit clear: regulator standby in sleep
// - stall execution until regulator recovers
// - retention needs fuse zero, enable one
// - retention regulator only during sleep
// - retention keeps ram, watchdog, timer, rtc
// - sleep_select picks sleep or idle
module ppg_ctrl
  import ppg_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // cpu power events
  input  wire logic                  wait_exec,
  input  wire logic                  wake_event,
  input  wire logic                  vreg_ready,
  input  wire logic                  retention_fuse,
  // peripheral clock gating
  input  wire logic [NUM_PERIPH-1:0] periph_clk_in,
  output logic [NUM_PERIPH-1:0]      periph_clk_out,
  output logic [NUM_PERIPH-1:0]      periph_off,
  // power state outputs
  output ppg_pwr_out_t               pwr_out
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [31:0]   lock_r;              // disable_lock_control
  logic [31:0]   md_r [1:7];          // module_disable_1..7
  logic [31:0]   pwr_r;               // power_control
  logic [31:0]   osc_r;               // oscillator_control
  logic [1:0]    unlk_r;              // unlock sequence progress
  ppg_pm_state_t pm_r;                // power mode state
  ppg_pm_state_t pm_nxt;
  logic [7:0]    wake_cnt_r;          // regulator recovery counter
  logic          stby_used_r;         // last sleep put regulator in standby
  localparam int IDX_TMR1 = 10;       // clock kept in retention
  localparam int IDX_RTC  = 15;       // clock kept in retention

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic          aw_hold_r;           // address captured
  logic          w_hold_r;            // data captured
  logic [7:0]    awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          wr_fire;             // both halves present
  logic [31:0]   rd_val;
  logic          rd_hit;
  logic          wr_hit;

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // mask of implemented bits per disable index
  function automatic logic [31:0] md_mask(input int idx);
    case (idx)
      1: md_mask = MASK_MD1;
      2: md_mask = MASK_MD2;
      3: md_mask = MASK_MD3;
      4: md_mask = MASK_MD4;
      5: md_mask = MASK_MD5;
      6: md_mask = MASK_MD6;
      default: md_mask = MASK_MD7;
    endcase
  endfunction

  // decode an address to a known register
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= OFS_OSC_CTL) && (a[1:0] == 2'h0);
  endfunction

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // capture write address and data independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= RST_ZERO;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  assign wr_hit = addr_ok(awaddr_r);

  // write response: okay even when a locked write is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence and lock register
  // ----------------------------------------------------------------
  // two keys in a row open the gate; any other write to the port closes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlk_r <= 2'h0;
    end else if (wr_fire && awaddr_r == OFS_SYS_UNLK) begin
      if (wdata_r == UNLK_KEY1)
        unlk_r <= 2'h1;
      else if (wdata_r == UNLK_KEY2 && unlk_r == 2'h1)
        unlk_r <= 2'h2;
      else
        unlk_r <= 2'h0;
    end
  end

  // lock bit moves only while unlocked; it resets open, like the disables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= RST_ZERO;
    end else if (wr_fire && awaddr_r == OFS_LOCK_CTL && unlk_r == 2'h2) begin
      lock_r <= merge(lock_r, wdata_r, wstrb_r, MASK_LOCK);
    end
  end

  // ----------------------------------------------------------------
  // disable registers
  // ----------------------------------------------------------------
  // one generate slice per register; a write while locked is dropped
  generate
    for (genvar g = 1; g <= 7; g++) begin : g_md
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          md_r[g] <= RST_ZERO;
        end else if (wr_fire && awaddr_r == OFS_MD1 + 8'(4 * (g - 1))
                     && !lock_r[BIT_LOCK]) begin
          md_r[g] <= merge(md_r[g], wdata_r, wstrb_r, md_mask(g));
        end
      end
    end
  endgenerate

  // power control written directly; oscillator control behind the system unlock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_r <= RST_PWR;
      osc_r <= RST_ZERO;
    end else if (wr_fire) begin
      if (awaddr_r == OFS_PWR_CTL)
        pwr_r <= merge(pwr_r, wdata_r, wstrb_r, MASK_PWR);
      if (awaddr_r == OFS_OSC_CTL && unlk_r == 2'h2)
        osc_r <= merge(osc_r, wdata_r, wstrb_r, MASK_OSC);
    end
  end

  // ----------------------------------------------------------------
  // peripheral disable map
  // ----------------------------------------------------------------
  // one line per peripheral; also feeds each peripheral's own clock gate
  always_comb begin
    periph_off[0]  = md_r[1][BIT_CONV];
    periph_off[1]  = md_r[1][BIT_VREF];
    periph_off[2]  = md_r[1][BIT_VDET];
    periph_off[3]  = md_r[2][BIT_CMP1];
    periph_off[4]  = md_r[2][BIT_CMP2];
    periph_off[5]  = md_r[2][BIT_LC1];
    periph_off[6]  = md_r[2][BIT_LC2];
    periph_off[7]  = md_r[3][BIT_CC1];
    periph_off[8]  = md_r[3][BIT_CC2];
    periph_off[9]  = md_r[3][BIT_CC3];
    periph_off[10] = md_r[4][BIT_TMR1];
    periph_off[11] = md_r[5][BIT_UART1];
    periph_off[12] = md_r[5][BIT_UART2];
    periph_off[13] = md_r[5][BIT_SPI1];
    periph_off[14] = md_r[5][BIT_SPI2];
    periph_off[15] = md_r[6][BIT_RTC];
    periph_off[16] = md_r[6][BIT_REFO];
    periph_off[17] = md_r[7][BIT_CRC];
  end
  // periph_off also stops that peripheral's clock in the g_cg gates

  // ----------------------------------------------------------------
  // clock gates
  // ----------------------------------------------------------------
  // enable latched while the source clock is low, so a bit change never
  // chops a high phase; timer1 and rtc keep running in retention
  generate
    for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_cg
      logic en_lat;
      always_latch begin
        if (!periph_clk_in[p])
          en_lat <= !periph_off[p] && (!pwr_out.core_logic_off ||
                    p == IDX_TMR1 || p == IDX_RTC);
      end
      assign periph_clk_out[p] = periph_clk_in[p] & en_lat;
    end
  endgenerate

  // ----------------------------------------------------------------
  // power mode sequencing
  // ----------------------------------------------------------------
  // run -> idle or sleep on wait; sleep -> wake after standby, held until regulator is up and the count ends
  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      PM_RUN:
        if (wait_exec)
          pm_nxt = osc_r[BIT_SLEEP_SEL] ? PM_SLP : PM_IDLE;
      PM_IDLE:
        if (wake_event)
          pm_nxt = PM_RUN;
      PM_SLP:
        if (wake_event)
          pm_nxt = stby_used_r ? PM_WAKE : PM_RUN;
      PM_WAKE:
        if (vreg_ready && wake_cnt_r == 8'h00)
          pm_nxt = PM_RUN;
      default:
        pm_nxt = PM_RUN;
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pm_r <= PM_RUN;
    else
      pm_r <= pm_nxt;
  end

  // note on entry whether the regulator goes to standby
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stby_used_r <= 1'b0;
    else if (pm_r == PM_RUN && pm_nxt == PM_SLP)
      stby_used_r <= !pwr_r[BIT_VREG_STBY];
  end

  // recovery counter: minimum regulator settle time
  always_ff @(posedge aclk) begin
    if (!aresetn)
      wake_cnt_r <= 8'h00;
    else if (pm_r == PM_SLP)
      wake_cnt_r <= VREG_WAKE_CNT;
    else if (pm_r == PM_WAKE && wake_cnt_r != 8'h00)
      wake_cnt_r <= wake_cnt_r - 8'h01;
  end

  // registered power outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_out <= '0;
    end else begin
      pwr_out.regulator_standby <= (pm_nxt == PM_SLP) &&
                                   !pwr_r[BIT_VREG_STBY];
      pwr_out.retention_on      <= (pm_nxt == PM_SLP) && !retention_fuse &&
                                   pwr_r[BIT_RET_EN];
      pwr_out.core_logic_off    <= (pm_nxt == PM_SLP) && !retention_fuse &&
                                   pwr_r[BIT_RET_EN];
      pwr_out.exec_stall        <= (pm_nxt != PM_RUN);
      pwr_out.sleeping          <= (pm_nxt == PM_SLP);
      pwr_out.idling            <= (pm_nxt == PM_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = addr_ok(s_axi_araddr);
    case (s_axi_araddr)
      OFS_LOCK_CTL: rd_val = lock_r;
      OFS_MD1:      rd_val = md_r[1];
      OFS_MD2:      rd_val = md_r[2];
      OFS_MD3:      rd_val = md_r[3];
      OFS_MD4:      rd_val = md_r[4];
      OFS_MD5:      rd_val = md_r[5];
      OFS_MD6:      rd_val = md_r[6];
      OFS_MD7:      rd_val = md_r[7];
      OFS_PWR_CTL:  rd_val = pwr_r;
      OFS_STATUS:   rd_val = {26'h0, pwr_out};
      OFS_OSC_CTL:  rd_val = osc_r;
      default:      rd_val = RST_ZERO;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // one-cycle read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RST_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ppg_ctrl

// [rtl/ppg_pkg.sv]
// package for the peripheral power gating controller
// assumes a 32-bit axi4-lite register bus and a single system clock
package ppg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOCK_CTL  = 8'h00; // disable_lock_control
  localparam logic [7:0] OFS_MD1       = 8'h04; // module_disable_1
  localparam logic [7:0] OFS_MD2       = 8'h08;
  localparam logic [7:0] OFS_MD3       = 8'h0C;
  localparam logic [7:0] OFS_MD4       = 8'h10;
  localparam logic [7:0] OFS_MD5       = 8'h14;
  localparam logic [7:0] OFS_MD6       = 8'h18;
  localparam logic [7:0] OFS_MD7       = 8'h1C;
  localparam logic [7:0] OFS_PWR_CTL   = 8'h20; // power_control
  localparam logic [7:0] OFS_SYS_UNLK  = 8'h24; // system unlock key port
  localparam logic [7:0] OFS_STATUS    = 8'h28; // live state, read only
  localparam logic [7:0] OFS_OSC_CTL   = 8'h2C; // oscillator_control

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_LOCK        = 11; // disable_write_lock
  localparam int BIT_CONV        = 0;  // module_disable_1
  localparam int BIT_VREF        = 12;
  localparam int BIT_VDET        = 20;
  localparam int BIT_CMP1        = 0;  // module_disable_2
  localparam int BIT_CMP2        = 1;
  localparam int BIT_LC1         = 24;
  localparam int BIT_LC2         = 25;
  localparam int BIT_CC1         = 8;  // module_disable_3
  localparam int BIT_CC2         = 9;
  localparam int BIT_CC3         = 10;
  localparam int BIT_TMR1        = 0;  // module_disable_4
  localparam int BIT_UART1       = 0;  // module_disable_5
  localparam int BIT_UART2       = 1;
  localparam int BIT_SPI1        = 8;
  localparam int BIT_SPI2        = 9;
  localparam int BIT_RTC         = 0;  // module_disable_6
  localparam int BIT_REFO        = 8;
  localparam int BIT_CRC         = 3;  // module_disable_7
  localparam int BIT_VREG_STBY   = 0;  // regulator_standby_ctl
  localparam int BIT_RET_EN      = 1;  // retention_enable
  localparam int BIT_SLEEP_SEL   = 4;  // sleep_select
  localparam int NUM_PERIPH      = 18;

  // implemented-bit masks per disable, lock, power and oscillator register
  localparam logic [31:0] MASK_MD1  = 32'h0010_1001;
  localparam logic [31:0] MASK_MD2  = 32'h0300_0003;
  localparam logic [31:0] MASK_MD3  = 32'h0000_0700;
  localparam logic [31:0] MASK_MD4  = 32'h0000_0001;
  localparam logic [31:0] MASK_MD5  = 32'h0000_0303;
  localparam logic [31:0] MASK_MD6  = 32'h0000_0101;
  localparam logic [31:0] MASK_MD7  = 32'h0000_0008;
  localparam logic [31:0] MASK_LOCK = 32'h0000_0800;
  localparam logic [31:0] MASK_PWR  = 32'h0000_0003;
  localparam logic [31:0] MASK_OSC  = 32'h0000_0010;

  // ----------------------------------------------------------------
  // reset values and keys
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_PWR    = 32'h0000_0001; // regulator normal
  localparam logic [31:0] UNLK_KEY1  = 32'hAA99_6655;
  localparam logic [31:0] UNLK_KEY2  = 32'h5566_99AA;
  localparam logic [31:0] UNLK_RELOCK= 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR= 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 100;
  localparam int VREG_WAKE_NS    = 10000; // regulator recovery, minimum
  localparam int VREG_WAKE_CYC   = (VREG_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] VREG_WAKE_CNT = 8'(VREG_WAKE_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PM_RUN  = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_SLP  = 4'b0100,
    PM_WAKE = 4'b1000
  } ppg_pm_state_t;

  typedef struct packed {
    logic regulator_standby;  // main regulator in standby
    logic retention_on;       // retention regulator active
    logic core_logic_off;     // non-retained core logic unpowered
    logic exec_stall;         // code execution held off
    logic sleeping;
    logic idling;
  } ppg_pwr_out_t;

endpackage : ppg_pkg

// [verif/ppg_ctrl_assertions.sv]
// port checker for the power gating controller
// bound onto ppg_ctrl, sees its ports only
`timescale 1ns/1ps
module ppg_ctrl_chk
  import ppg_pkg::*;
(
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // register bus
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // power and gating
  input wire logic                  retention_fuse,
  input wire logic [NUM_PERIPH-1:0] periph_off,
  input wire ppg_pwr_out_t          pwr_out
);
  // ------
  // single clock domain
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp not held");
  a_wr_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2C
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // disables move only with a write
  a_off_by_write: assert property (
    $changed(periph_off) |-> $rose(s_axi_bvalid))
    else $error("disable moved without write");
  a_ret_in_sleep: assert property (
    pwr_out.retention_on |-> pwr_out.sleeping && !retention_fuse)
    else $error("retention outside sleep");
  a_halt_stalls: assert property (
    pwr_out.sleeping || pwr_out.idling |-> pwr_out.exec_stall)
    else $error("halt without stall");
  a_stby_stalls: assert property (
    pwr_out.regulator_standby |-> pwr_out.exec_stall)
    else $error("standby without stall");

  // scenarios
  c_stby_sleep: cover property (pwr_out.sleeping && pwr_out.regulator_standby);
  c_retention: cover property (pwr_out.retention_on);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // ppg_ctrl_chk

bind ppg_ctrl ppg_ctrl_chk i_ppg_ctrl_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .retention_fuse, .periph_off, .pwr_out
);

// [verif/ppg_ctrl_bench.sv]
// bench for the power gating controller: bus tasks, queue monitor
// assumes package, design and checker are compiled first
`timescale 1ns/1ps
module ppg_ctrl_bench;
  import ppg_pkg::*;
  // ------
  // pins and bookkeeping
  // ------
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]            s_axi_wstrb = 4'hF; // whole words only
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_arready, s_axi_rvalid;
  logic                  wait_exec = 1'b0, wake_event = 1'b0;
  logic                  vreg_ready = 1'b1, retention_fuse = 1'b1;
  logic [NUM_PERIPH-1:0] periph_clk_in, periph_clk_out, periph_off;
  ppg_pwr_out_t          pwr_out;
  int                    err_total = 0, compares = 0;
  logic [1:0]            bq [$];  // expected write responses
  logic [33:0]           rq [$];  // expected {rresp, rdata}
  // {offset, bit} per peripheral
  localparam logic [15:0] MAP [NUM_PERIPH] = '{16'h0400, 16'h040C, 16'h0414,
    16'h0800, 16'h0801, 16'h0818, 16'h0819, 16'h0C08, 16'h0C09, 16'h0C0A,
    16'h1000, 16'h1400, 16'h1401, 16'h1408, 16'h1409, 16'h1800, 16'h1808, 16'h1C03};
  localparam logic [31:0] MSK [8] = '{MASK_LOCK, MASK_MD1, MASK_MD2, MASK_MD3,
    MASK_MD4, MASK_MD5, MASK_MD6, MASK_MD7};

  // system clock
  initial begin
    forever #50 aclk = ~aclk;
  end
  // source clocks follow aclk
  assign periph_clk_in = {NUM_PERIPH{aclk}};

  ppg_ctrl i_ppg_ctrl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_exec, .wake_event, .vreg_ready,
    .retention_fuse, .periph_clk_in, .periph_clk_out, .periph_off, .pwr_out
  );

  // ------
  // compare, verdict, bus tasks
  // ------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // an expired wait counts as a mismatch
  task automatic timed_out();
    err_total++;
    close_out();
  endtask

  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) timed_out();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] ex);
    int n;
    @(posedge aclk);
    rq.push_back(ex);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) timed_out();
  endtask

  // unlock, write, relock
  task automatic prot_wr(input logic [7:0] a, input logic [31:0] d);
    wr(OFS_SYS_UNLK, UNLK_KEY1, RESP_OKAY);
    wr(OFS_SYS_UNLK, UNLK_KEY2, RESP_OKAY);
    wr(a, d, RESP_OKAY);
    wr(OFS_SYS_UNLK, UNLK_RELOCK, RESP_OKAY);
  endtask

  // one-cycle wait or wake pulse, then settle
  task automatic pulse(input bit wk);
    @(posedge aclk);
    if (wk) wake_event <= 1'b1;
    else wait_exec <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    wait_exec <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // bounded wait for run
  task automatic wait_run();
    int n;
    for (n = 0; n < 300 && pwr_out.exec_stall !== 1'b0; n++) @(posedge aclk);
    if (n == 300) timed_out();
    chk(pwr_out, 6'h00);
  endtask

  // monitor: oldest note against each response
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // ------
  // main sequence
  // ------
  initial begin
    int i;
    logic [31:0] d;
    logic [NUM_PERIPH-1:0] oh;
    void'($urandom(32'h7E02500B));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'(4 * i), {RESP_OKAY, RST_ZERO});
    rd(OFS_PWR_CTL, {RESP_OKAY, RST_PWR});
    // random words: only implemented disables stick
    for (i = 1; i < 8; i++) begin
      d = $urandom();
      wr(8'(4 * i), d, RESP_OKAY);
      rd(8'(4 * i), {RESP_OKAY, d & MSK[i]});
      wr(8'(4 * i), 32'h0, RESP_OKAY);
    end
    // each disable alone
    for (i = 0; i < NUM_PERIPH; i++) begin
      oh = NUM_PERIPH'(1) << i;
      wr(MAP[i][15:8], 32'h1 << MAP[i][7:0], RESP_OKAY);
      repeat (2) @(posedge aclk);
      #20;
      chk(periph_off, oh);
      chk(periph_clk_out, NUM_PERIPH'(~oh));
      wr(MAP[i][15:8], 32'h0, RESP_OKAY);
    end
    #20;
    chk(periph_clk_out, {NUM_PERIPH{1'b1}});
    // lock, with and without the key sequence
    wr(OFS_LOCK_CTL, MASK_LOCK, RESP_OKAY);
    rd(OFS_LOCK_CTL, {RESP_OKAY, RST_ZERO});
    prot_wr(OFS_LOCK_CTL, MASK_LOCK);
    rd(OFS_LOCK_CTL, {RESP_OKAY, MASK_LOCK});
    wr(OFS_MD5, MASK_MD5, RESP_OKAY);
    rd(OFS_MD5, {RESP_OKAY, RST_ZERO});
    wr(OFS_LOCK_CTL, 32'h0, RESP_OKAY);
    rd(OFS_LOCK_CTL, {RESP_OKAY, MASK_LOCK});
    prot_wr(OFS_LOCK_CTL, 32'h0);
    wr(OFS_MD5, MASK_MD5, RESP_OKAY);
    rd(OFS_MD5, {RESP_OKAY, MASK_MD5});
    wr(OFS_MD5, 32'h0, RESP_OKAY);
    // unmapped and unaligned places
    wr(8'h30, 32'h0, RESP_SLVERR);
    rd(8'h30, {RESP_SLVERR, 32'h0});
    rd(8'h05, {RESP_SLVERR, 32'h0});
    // standby sleep, slow regulator recovery
    wr(OFS_PWR_CTL, 32'h0, RESP_OKAY);
    prot_wr(OFS_OSC_CTL, MASK_OSC);
    pulse(1'b0);
    chk(pwr_out, 6'h26);
    vreg_ready <= 1'b0;
    pulse(1'b1);
    repeat (150) @(posedge aclk);
    chk(pwr_out.exec_stall, 1'b1);
    vreg_ready <= 1'b1;
    wait_run();
    // standby again, regulator good
    pulse(1'b0);
    pulse(1'b1);
    repeat (60) @(posedge aclk);
    chk(pwr_out.exec_stall, 1'b1);
    wait_run();
    // retention by fuse and enable
    retention_fuse <= 1'b0;
    wr(OFS_PWR_CTL, 32'h3, RESP_OKAY);
    pulse(1'b0);
    chk(pwr_out, 6'h1E);
    #20;
    chk(periph_clk_out, 18'h08400);
    pulse(1'b1);
    wait_run();
    retention_fuse <= 1'b1;
    pulse(1'b0);
    chk(pwr_out, 6'h06);
    pulse(1'b1);
    wait_run();
    // idle: no retention
    retention_fuse <= 1'b0;
    prot_wr(OFS_OSC_CTL, 32'h0);
    pulse(1'b0);
    chk(pwr_out, 6'h05);
    pulse(1'b1);
    wait_run();
    close_out();
  end
endmodule // ppg_ctrl_bench
